//--- hw/rof_regs.svh
// Register offsets, reset values and timing figures of the RMS, over-current and period block.
// Included by the block; holds definitions only.
`ifndef ROF_REGS_SVH
`define ROF_REGS_SVH
`define ROF_ADDR_IRMS 8'h03
`define ROF_ADDR_VRMS 8'h04
`define ROF_ADDR_FAST 8'h05
`define ROF_ADDR_PERIOD 8'h08
`define ROF_ADDR_THRESH 8'h15
`define ROF_ADDR_FASTWIN 8'h16
`define ROF_ADDR_PERCYC 8'h17
`define ROF_ADDR_OUTSEL 8'h18
`define ROF_ADDR_MODE 8'h19
`define ROF_ADDR_STATUS 8'h1A
`define ROF_ADDR_MASK 8'h1B
`define ROF_RST_PERIOD 16'h4E20
`define ROF_RST_THRESH 16'hFFFF
`define ROF_RST_FASTWIN 3'h1
`define ROF_RST_PERCYC 2'h3
`define ROF_RST_OUTSEL 6'h24
`define ROF_RST_MODE 24'h000000
`define ROF_MODE_RMS_SEL 3
`define ROF_MODE_RATE_SEL 5
`define ROF_SEL_OVERCUR 2'h1
`define ROF_ST_RMS 0
`define ROF_ST_FAST 1
`define ROF_ST_OVERCUR 2
`define ROF_ST_PERIOD 3
`define ROF_VZX_TH 24'h004000
`define ROF_LPF_SHIFT 8
`define ROF_AVG_SHIFT 6
`define ROF_CLK_NS 10
`define ROF_RMS_FAST_MS 400
`define ROF_HALF50_NS 10000000
`define ROF_HALF60_NS 8333333
`define ROF_TICK_NS 2000
`endif

//--- hw/rof_pkg.sv
// Types shared by the RMS, over-current and period block.
// Assumes the constants header is on the include path.
package rof_pkg;
  typedef struct packed {
    logic valid;
    logic signed [19:0] cur;
    logic signed [19:0] vol;
  } rof_wave_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [23:0] wdata;
    logic wr;
    logic rd;
  } rof_bus_type;
endpackage : rof_pkg

//--- hw/rof_meter.sv
// RMS averaging, fast current magnitude with over-current compare, and line period meter.
// Assumes filtered waveform samples and the no-load flag arrive on clk_sys from upstream logic.
//
// Functional notes
// - RMS by square, lowpass, root, average
// - two 24-bit read-only RMS results, reset zero
// - RMS refresh 400ms, or 800ms when selected
// - no-load state forces current RMS zero
// - fast magnitude sums absolute current per window
// - threshold register 16 bits, resets to FFFF
// - magnitude bits 23:8 >= threshold raises over-current
// - window code: half,1,2,4,else 8 cycles
// - line rate bit sets nominal cycle length
// - period refresh after 2,4,8,16 cycles
// - period result 16 bits, resets to 4E20
// - period counted at 2us per count
// - low voltage RMS suspends period measurement
// - voltage gate near one thirty-second full scale
// - pin select code 01 outputs over-current
`include "rof_regs.svh"
`timescale 1ns/100ps
module rof_meter
  import rof_pkg::*;
#(
  parameter int RMS_BASE_CYC = `ROF_RMS_FAST_MS * 1000000 / `ROF_CLK_NS,
  parameter int HALF50_CYC = `ROF_HALF50_NS / `ROF_CLK_NS,
  parameter int HALF60_CYC = `ROF_HALF60_NS / `ROF_CLK_NS,
  parameter int TICK_CYC = `ROF_TICK_NS / `ROF_CLK_NS
)
(
  input wire logic clk_sys, // 100 MHz clock
  input wire logic rst, // Synchronous reset, high
  input wire rof_wave_type wave, // Filtered samples with valid
  input wire logic no_load, // Current channel anti-creep state
  input wire rof_bus_type bus, // Register port request
  output logic [23:0] rd_data, // Read data, cycle after read
  output logic irq, // Unmasked status pending
  output logic [2:0] logic_pin // Three logic output pins
);
  if (RMS_BASE_CYC < 2 || HALF50_CYC < 2 || HALF60_CYC < 2 || TICK_CYC < 2
    || TICK_CYC > 65536)
  begin : g_bad_params
    $error("rof_meter: timing parameters out of range");
  end

  function automatic logic [19:0] rof_isqrt(input logic [39:0] v);
    logic [19:0] r;
    logic [19:0] c;
    r = 20'h00000;
    for (int b = 19; b >= 0; b--)
    begin
      c = r | (20'h00001 << b);
      if ({20'h00000, c} * {20'h00000, c} <= v)
        r = c;
    end
    return r;
  endfunction : rof_isqrt

  function automatic logic [19:0] rof_abs(input logic signed [19:0] s);
    return s[19] ? 20'(-s) : 20'(s);
  endfunction : rof_abs

  logic [23:0] cur_rms_reg, vol_rms_reg, fast_reg, mode_reg;
  logic [15:0] period_reg, thresh_reg;
  logic [2:0] fastwin_reg;
  logic [1:0] percyc_reg;
  logic [5:0] outsel_reg;
  logic [3:0] status_reg, mask_reg;
  logic [23:0] rd_data_reg;
  logic irq_reg, oc_reg;
  logic [2:0] pin_reg;
  logic [23:0] avg_reg [2];
  logic [39:0] lpf_reg [2];
  logic rms_tick, fast_done, per_done, oc_rise;
  logic wr_status;

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_rms
    logic [19:0] mag;
    logic [39:0] sq;
    logic [23:0] inst;
    assign mag = rof_abs(ch == 0 ? wave.cur : wave.vol);
    assign sq = {20'h00000, mag} * {20'h00000, mag};
    assign inst = {4'h0, rof_isqrt(lpf_reg[ch])};
    always_ff @(posedge clk_sys)
    begin
      if (rst)
      begin
        lpf_reg[ch] <= 40'h0000000000;
        avg_reg[ch] <= 24'h000000;
      end
      else if (wave.valid)
      begin
        lpf_reg[ch] <= lpf_reg[ch] - (lpf_reg[ch] >> `ROF_LPF_SHIFT) + (sq >> `ROF_LPF_SHIFT);
        avg_reg[ch] <= avg_reg[ch] - (avg_reg[ch] >> `ROF_AVG_SHIFT)
          + (inst >> `ROF_AVG_SHIFT);
      end
    end
  end

  logic [31:0] rms_cnt_reg;
  logic [31:0] rms_target;
  assign rms_target = mode_reg[`ROF_MODE_RMS_SEL] ? 32'(2 * RMS_BASE_CYC) : 32'(RMS_BASE_CYC);
  assign rms_tick = (rms_cnt_reg >= rms_target - 32'h00000001);
  always_ff @(posedge clk_sys)
  begin
    // A new refresh rate restarts the interval
    if (rst || rms_tick || (bus.wr && bus.addr == `ROF_ADDR_MODE))
      rms_cnt_reg <= 32'h00000000;
    else
      rms_cnt_reg <= rms_cnt_reg + 32'h00000001;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cur_rms_reg <= 24'h000000;
      vol_rms_reg <= 24'h000000;
    end
    else
    begin
      if (no_load)
        cur_rms_reg <= 24'h000000;
      else if (rms_tick)
        cur_rms_reg <= avg_reg[0];
      if (rms_tick)
        vol_rms_reg <= avg_reg[1];
    end
  end

  logic [31:0] half_cnt_reg;
  logic [31:0] half_len;
  logic half_tick;
  assign half_len = mode_reg[`ROF_MODE_RATE_SEL] ? 32'(HALF60_CYC) : 32'(HALF50_CYC);
  assign half_tick = (half_cnt_reg >= half_len - 32'h00000001);
  always_ff @(posedge clk_sys)
  begin
    if (rst || half_tick)
      half_cnt_reg <= 32'h00000000;
    else
      half_cnt_reg <= half_cnt_reg + 32'h00000001;
  end

  logic [4:0] win_halves;
  always_comb
  begin
    unique case (fastwin_reg)
      3'h0: win_halves = 5'h01;
      3'h1: win_halves = 5'h02;
      3'h2: win_halves = 5'h04;
      3'h3: win_halves = 5'h08;
      default: win_halves = 5'h10;
    endcase
  end

  logic [4:0] halves_reg;
  logic [24:0] fast_acc_reg;
  assign fast_done = half_tick && (halves_reg + 5'h01 >= win_halves);
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      halves_reg <= 5'h00;
      fast_acc_reg <= 25'h0000000;
      fast_reg <= 24'h000000;
    end
    else
    begin
      if (fast_done)
      begin
        halves_reg <= 5'h00;
        // The sample of the closing cycle opens the next window
        fast_acc_reg <= wave.valid ? {5'h00, rof_abs(wave.cur)} : 25'h0000000;
        fast_reg <= fast_acc_reg[24] ? 24'hFFFFFF : fast_acc_reg[23:0];
      end
      else
      begin
        if (half_tick)
          halves_reg <= halves_reg + 5'h01;
        if (wave.valid && !fast_acc_reg[24])
          fast_acc_reg <= fast_acc_reg + {5'h00, rof_abs(wave.cur)};
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      oc_reg <= 1'b0;
    else if (fast_done)
      oc_reg <= ((fast_acc_reg[24] ? 16'hFFFF : fast_acc_reg[23:8]) >= thresh_reg);
  end
  assign oc_rise = fast_done && !oc_reg
    && ((fast_acc_reg[24] ? 16'hFFFF : fast_acc_reg[23:8]) >= thresh_reg);

  for (genvar p = 0; p < 3; p++)
  begin : g_pin
    always_ff @(posedge clk_sys)
    begin
      if (rst)
        pin_reg[p] <= 1'b0;
      else
        pin_reg[p] <= (outsel_reg[2*p +: 2] == `ROF_SEL_OVERCUR) && oc_reg;
    end
  end

  logic [15:0] tick_cnt_reg;
  logic tick;
  assign tick = (tick_cnt_reg == 16'(TICK_CYC - 1));
  always_ff @(posedge clk_sys)
  begin
    if (rst || tick)
      tick_cnt_reg <= 16'h0000;
    else
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
  end

  logic gate;
  logic sign_reg, armed_reg;
  logic [23:0] per_cnt_reg;
  logic [4:0] cyc_cnt_reg;
  logic [4:0] cyc_target;
  logic rise;
  assign gate = (avg_reg[1] >= `ROF_VZX_TH);
  assign rise = wave.valid && sign_reg && !wave.vol[19];
  assign cyc_target = 5'h02 << percyc_reg;
  // Passing the target after a code change still closes the window
  assign per_done = gate && rise && armed_reg && (cyc_cnt_reg + 5'h01 >= cyc_target);
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      sign_reg <= 1'b0;
    else if (wave.valid)
      sign_reg <= wave.vol[19];
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || !gate)
    begin
      armed_reg <= 1'b0;
      per_cnt_reg <= 24'h000000;
      cyc_cnt_reg <= 5'h00;
    end
    else if (rise)
    begin
      armed_reg <= 1'b1;
      cyc_cnt_reg <= (per_done || !armed_reg) ? 5'h00 : cyc_cnt_reg + 5'h01;
      // A new window counts the tick of its opening cycle
      if (armed_reg && !per_done)
        per_cnt_reg <= per_cnt_reg + {23'h000000, tick};
      else
        per_cnt_reg <= {23'h000000, tick};
    end
    else if (tick && per_cnt_reg != 24'hFFFFFF)
      per_cnt_reg <= per_cnt_reg + 24'h000001;
  end

  logic [23:0] per_scaled;
  assign per_scaled = per_cnt_reg >> percyc_reg;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      period_reg <= `ROF_RST_PERIOD;
    else if (per_done)
      period_reg <= (per_scaled[23:16] != 8'h00) ? 16'hFFFF : per_scaled[15:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      thresh_reg <= `ROF_RST_THRESH;
      fastwin_reg <= `ROF_RST_FASTWIN;
      percyc_reg <= `ROF_RST_PERCYC;
      outsel_reg <= `ROF_RST_OUTSEL;
      mode_reg <= `ROF_RST_MODE;
      mask_reg <= 4'h0;
    end
    else if (bus.wr)
    begin
      unique case (bus.addr)
        `ROF_ADDR_THRESH: thresh_reg <= bus.wdata[15:0];
        `ROF_ADDR_FASTWIN: fastwin_reg <= bus.wdata[2:0];
        `ROF_ADDR_PERCYC: percyc_reg <= bus.wdata[1:0];
        `ROF_ADDR_OUTSEL: outsel_reg <= bus.wdata[5:0];
        `ROF_ADDR_MODE: mode_reg <= bus.wdata;
        `ROF_ADDR_MASK: mask_reg <= bus.wdata[3:0];
        default: ;
      endcase
    end
  end

  // Sticky events, set wins over write-one clear
  logic [3:0] events;
  assign events = {per_done, oc_rise, fast_done, rms_tick};
  assign wr_status = bus.wr && (bus.addr == `ROF_ADDR_STATUS);
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      status_reg <= 4'h0;
    else
      status_reg <= (status_reg & ~(wr_status ? bus.wdata[3:0] : 4'h0)) | events;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(status_reg & mask_reg);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || !bus.rd)
      rd_data_reg <= 24'h000000;
    else
    begin
      unique case (bus.addr)
        `ROF_ADDR_IRMS: rd_data_reg <= cur_rms_reg;
        `ROF_ADDR_VRMS: rd_data_reg <= vol_rms_reg;
        `ROF_ADDR_FAST: rd_data_reg <= fast_reg;
        `ROF_ADDR_PERIOD: rd_data_reg <= {8'h00, period_reg};
        `ROF_ADDR_THRESH: rd_data_reg <= {8'h00, thresh_reg};
        `ROF_ADDR_FASTWIN: rd_data_reg <= {21'h000000, fastwin_reg};
        `ROF_ADDR_PERCYC: rd_data_reg <= {22'h000000, percyc_reg};
        `ROF_ADDR_OUTSEL: rd_data_reg <= {18'h00000, outsel_reg};
        `ROF_ADDR_MODE: rd_data_reg <= mode_reg;
        `ROF_ADDR_STATUS: rd_data_reg <= {20'h00000, status_reg};
        `ROF_ADDR_MASK: rd_data_reg <= {20'h00000, mask_reg};
        default: rd_data_reg <= 24'h000000;
      endcase
    end
  end

  assign rd_data = rd_data_reg;
  assign irq = irq_reg;
  assign logic_pin = pin_reg;

  rms_reset_a: assert property (@(posedge clk_sys) $past(rst) |->
    cur_rms_reg == 24'h000000 && vol_rms_reg == 24'h000000) else $error("RMS not zero after reset");
  rms_period_a: assert property (@(posedge clk_sys) disable iff (rst)
    rms_cnt_reg < rms_target) else $error("RMS refresh counter past interval");
  creep_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    no_load |=> cur_rms_reg == 24'h000000) else $error("current RMS not forced zero");
  thresh_reset_a: assert property (@(posedge clk_sys) $past(rst) |->
    thresh_reg == 16'hFFFF) else $error("threshold reset value wrong");
  oc_compare_a: assert property (@(posedge clk_sys) disable iff (rst)
    fast_done && !bus.wr |=> oc_reg == (fast_reg[23:8] >= thresh_reg))
    else $error("over-current level mismatch");
  win_code_a: assert property (@(posedge clk_sys) disable iff (rst)
    fastwin_reg == 3'h0 && half_tick |-> fast_done) else $error("half cycle window wrong");
  period_reset_a: assert property (@(posedge clk_sys) $past(rst) |->
    period_reg == 16'h4E20) else $error("period reset value wrong");
  period_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !gate |=> $stable(period_reg)) else $error("period changed while suspended");
  pin_route_a: assert property (@(posedge clk_sys) disable iff (rst)
    outsel_reg[1:0] == 2'h1 && oc_reg && !bus.wr |=> pin_reg[0])
    else $error("pin does not follow over-current");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (rst)
    |(status_reg & mask_reg) |=> irq_reg) else $error("interrupt not raised");
endmodule : rof_meter

//--- verification/rof_host_model.sv
// Host model: master on the plain register port of the meter block.
// Assumes one clock and read data standing only in the cycle after the read.
`timescale 1ns/100ps
module rof_host_model
  import rof_pkg::*;
(
  input wire logic clk_sys, // System clock
  output rof_bus_type bus, // Request to the block
  input wire logic [23:0] rd_data // Read reply
);
  initial bus = '0;

  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask : wr

  // Reply is taken at the edge that closes its only cycle
  task automatic rd(input logic [7:0] a, output logic [23:0] v);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 24'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    @(posedge clk_sys);
    v = rd_data;
  endtask : rd
endmodule : rof_host_model

//--- verification/rof_meter_tb.sv
// Self-checking bench of the RMS, over-current and period block.
// Assumes the host model and shortened timing parameters.
`timescale 1ns/100ps
module rof_meter_tb;
  import rof_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic no_load = 1'b0;
  rof_wave_type wave = '0;
  rof_bus_type bus;
  logic [23:0] rd_data;
  logic irq;
  logic [2:0] logic_pin;
  logic [23:0] d;
  int err_count = 0;
  int tests_run = 0;
  int half = 100;
  int ph = 0;
  logic signed [19:0] vamp = 20'sd20000;

  always #5 clk_sys = ~clk_sys;

  rof_meter #(.RMS_BASE_CYC(200), .HALF50_CYC(100), .HALF60_CYC(83), .TICK_CYC(2))
  u_rof_meter (.clk_sys(clk_sys), .rst(rst), .wave(wave), .no_load(no_load), .bus(bus),
    .rd_data(rd_data), .irq(irq), .logic_pin(logic_pin));
  rof_host_model u_rof_host_model (.clk_sys(clk_sys), .bus(bus), .rd_data(rd_data));

  // Square voltage of 2*half cycles, steady current, a sample every cycle
  always @(posedge clk_sys)
  begin
    ph <= (ph >= 2 * half - 1) ? 0 : ph + 1;
    wave <= '{valid: 1'b1, cur: 20'sd1000, vol: (ph < half) ? -vamp : vamp};
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic in_range(input string what, input logic [23:0] lo, input logic [23:0] hi);
    check(what, 24'(d >= lo && d <= hi), 24'h1);
  endtask : in_range

  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    u_rof_host_model.wr(a, v);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    u_rof_host_model.rd(a, d);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic wait_irq(input logic v);
    for (int i = 0; i < 4000 && irq !== v; i++)
      @(posedge clk_sys);
    check("irq", irq, v);
  endtask : wait_irq

  // Cycles between two consecutive settings of one status bit
  task automatic gap(input int bitn, input int exp);
    realtime t0;
    wr(8'h1B, 24'h1 << bitn);
    wr(8'h1A, 24'hFFFFFF);
    wait_irq(1'b0);
    wait_irq(1'b1);
    t0 = $realtime;
    wr(8'h1A, 24'hFFFFFF);
    wait_irq(1'b0);
    wait_irq(1'b1);
    d = 24'(int'(($realtime - t0) / 10.0));
    in_range("refresh gap", 24'(exp - 2), 24'(exp + 2));
    wr(8'h1B, 24'h0);
  endtask : gap

  task automatic t_reset();
    logic [7:0] addr [12] = '{8'h1A, 8'h05, 8'h03, 8'h04, 8'h08, 8'h15, 8'h16, 8'h17,
      8'h18, 8'h19, 8'h1B, 8'h06};
    logic [23:0] rv [12] = '{24'h0, 24'h0, 24'h0, 24'h0, 24'h4E20, 24'hFFFF, 24'h1, 24'h3,
      24'h24, 24'h0, 24'h0, 24'h0};
    check("irq", irq, 1'b0);
    check("pins", logic_pin, 3'h0);
    for (int i = 0; i < 12; i++)
    begin
      rd(addr[i]);
      check($sformatf("reg %h", addr[i]), d, rv[i]);
    end
    wr(8'h08, 24'h0);
    rd(8'h08);
    check("period write", d, 24'h4E20);
    wr(8'h15, 24'h1234);
    rd(8'h15);
    check("threshold", d, 24'h1234);
    $display("Test reset done");
  endtask : t_reset

  task automatic t_rms();
    cyc(8000);
    rd(8'h03);
    in_range("current rms", 24'h3A2, 24'h3E8);
    rd(8'h04);
    in_range("voltage rms", 24'h4DDA, 24'h4E20);
    no_load <= 1'b1;
    cyc(600);
    rd(8'h03);
    check("no-load rms", d, 24'h0);
    no_load <= 1'b0;
    gap(0, 200);
    wr(8'h19, 24'h8);
    gap(0, 400);
    wr(8'h19, 24'h0);
    $display("Test rms done");
  endtask : t_rms

  task automatic t_fast();
    int len [7] = '{100, 200, 400, 800, 1600, 1600, 166};
    logic [2:0] code [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h1};
    for (int i = 0; i < 7; i++)
    begin
      if (i == 6)
        wr(8'h19, 24'h20);
      wr(8'h16, {21'h0, code[i]});
      cyc(3600);
      rd(8'h05);
      in_range("fast", 24'((len[i] - 2) * 1000), 24'((len[i] + 2) * 1000));
    end
    wr(8'h19, 24'h0);
    $display("Test fast done");
  endtask : t_fast

  task automatic t_oc();
    logic [15:0] m;
    cyc(600);
    rd(8'h05);
    m = d[23:8];
    wr(8'h15, {8'h0, m});
    cyc(500);
    check("pins equal", logic_pin, 3'h2);
    wr(8'h18, 24'h15);
    cyc(4);
    check("pins all", logic_pin, 3'h7);
    wr(8'h18, 24'h0);
    cyc(4);
    check("pins none", logic_pin, 3'h0);
    wr(8'h18, 24'h24);
    wr(8'h15, {8'h0, m + 16'h1});
    cyc(500);
    check("pins above", logic_pin, 3'h0);
    wr(8'h1A, 24'hFFFFFF);
    wr(8'h15, {8'h0, m});
    cyc(500);
    check("irq masked", irq, 1'b0);
    rd(8'h1A);
    check("oc status", d[2], 1'b1);
    wr(8'h1B, 24'h4);
    cyc(4);
    check("irq on", irq, 1'b1);
    wr(8'h1A, 24'h4);
    cyc(4);
    check("irq clear", irq, 1'b0);
    wr(8'h1B, 24'h0);
    $display("Test overcurrent done");
  endtask : t_oc

  task automatic t_period();
    for (int c = 0; c < 4; c++)
    begin
      half <= 100 + 10 * c;
      wr(8'h17, 24'(c));
      cyc((2 << c) * 4 * half + 400);
      rd(8'h08);
      check("period", d, 24'(2 * half));
    end
    wr(8'h17, 24'h0);
    cyc(1200);
    vamp <= 20'sd8000;
    cyc(6000);
    half <= 100;
    cyc(2000);
    rd(8'h08);
    check("period held", d, 24'h104);
    vamp <= 20'sd20000;
    cyc(6000);
    rd(8'h08);
    check("period resumed", d, 24'hC8);
    $display("Test period done");
  endtask : t_period

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  initial
  begin
    cyc(16);
    rst <= 1'b0;
    t_reset();
    t_rms();
    t_fast();
    t_oc();
    t_period();
    finish_test();
  end

  initial
  begin
    #1000000;
    err_count++;
    finish_test();
  end
endmodule : rof_meter_tb
